/* File: core/tcm_timer.sv */
// Timer/counter core: normal and clear-on-compare modes with compare outputs
`timescale 1ns/1ns

// Operation
// [RULE_01] Mode field picks match action on output state and the pin source.
// [RULE_02] Reset clears every channel's output compare state to zero.
// [RULE_03] Nonzero mode field makes output state replace port data on pin.
// [RULE_04] Direction bit still drives pin direction; software must set output first.
// [RULE_05] Output state may be set while the pin is still an input.
// [RULE_06] Mode field has no effect on the capture unit.
// [RULE_07] Mode value zero leaves output state unchanged at a match.
// [RULE_08] New mode acts at next match; force strobe applies action now.
// [RULE_09] Counting depends only on waveform field, never on mode field.
// [RULE_10] Non-PWM: set, clear or toggle; PWM: inverted or non-inverted output (in PWM modes the code leaves the state unchanged).
// [RULE_11] Waveform mode 0 counts up only and wraps FFFF to 0000.
// [RULE_12] Normal mode sets overflow flag as counter becomes zero; service clears.
// [RULE_13] Counter may be written at any time in normal mode.
// [RULE_14] Clear-on-compare clears on compare A (mode 4) or capture (mode 12).
// [RULE_15] Reaching top sets compare A flag or capture flag respectively.
// [RULE_16] Top is not double buffered; top below count means wrap first.
// [RULE_17] Channel A mode 1 toggles output on every match.
// [RULE_18] Toggle rate is clock over 2*N*(1+top), N from 1,8,64,256,1024.
// [RULE_19] Clear-on-compare sets overflow when count passes MAX to zero.
// [RULE_20] Compare flag sets one timer tick after counter equals compare.
// [RULE_21] Force updates output state but sets no flag, leaves counter.
// [RULE_22] Counter write blocks compare matches in the following timer tick.
// [RULE_23] Counting, flag setting and match actions happen only on prescaled enable cycles.
// [RULE_24] Top clear beats increment; output action evaluated before clearing.
module tcm_timer (
	// Clock and reset
	input  wire logic                  CLOCK_IN,
	input  wire logic                  NRST_IN,
	// Mode control
	input  wire tcm_pkg::tcm_ctl_t     CTL_IN,
	input  wire logic [15:0]           COMPARE_A_IN,
	input  wire logic [15:0]           COMPARE_B_IN,
	input  wire logic [15:0]           CAPTURE_IN,
	// Counter write and force strobes
	input  wire logic                  COUNT_WR_IN,
	input  wire logic [15:0]           COUNT_DATA_IN,
	input  wire logic [1:0]            FORCE_IN,
	// Flag clears from interrupt service
	input  wire tcm_pkg::tcm_flags_t   FLAG_CLEAR_IN,
	// Port register bits of both compare pins
	input  wire logic [1:0]            PORT_DATA_IN,
	input  wire logic [1:0]            PIN_DIR_IN,
	// Status
	output logic [15:0]                COUNT_OUT,
	output tcm_pkg::tcm_flags_t        FLAGS_OUT,
	output logic [1:0]                 STATE_OUT,
	// Compare pins
	output logic [1:0]                 PIN_OUT,
	output logic [1:0]                 PIN_OE_N_OUT
);

	////////////////////////////////////////////////////////////////////////////
	function automatic logic is_non_pwm(input logic [3:0] wgm);
		is_non_pwm = (wgm == tcm_pkg::WGM_NORMAL) || (wgm == tcm_pkg::WGM_CTC_A)
			|| (wgm == tcm_pkg::WGM_CTC_CAP);
	endfunction

	function automatic logic apply_action(input logic cur, input logic [1:0] com);
		case (com)
			tcm_pkg::COM_TOGGLE: apply_action = ~cur;
			tcm_pkg::COM_CLEAR:  apply_action = 1'b0;
			tcm_pkg::COM_SET:    apply_action = 1'b1;
			default:             apply_action = cur;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	tcm_pkg::tcm_state_t st;
	tcm_pkg::tcm_state_t next_st;
	logic                tick;
	logic [1:0]          match;
	logic                top_match;
	logic                non_pwm;
	logic [1:0]          com [2];
	logic [15:0]         cmp [2];

	assign com[0]  = CTL_IN.channel_a_output_mode_field;
	assign com[1]  = CTL_IN.channel_b_output_mode_field;
	assign cmp[0]  = COMPARE_A_IN;
	assign cmp[1]  = COMPARE_B_IN;
	assign non_pwm = is_non_pwm(CTL_IN.waveform_generation_field);

	// [RULE_18] prescaler divide factor
	always_comb begin
		if (CTL_IN.clk_sel == tcm_pkg::SEL_DIV1) begin
			tick = 1'b1;
		end else if (CTL_IN.clk_sel == tcm_pkg::SEL_DIV8) begin
			tick = (st.pre & tcm_pkg::PRE_MASK8) == tcm_pkg::PRE_MASK8;
		end else if (CTL_IN.clk_sel == tcm_pkg::SEL_DIV64) begin
			tick = (st.pre & tcm_pkg::PRE_MASK64) == tcm_pkg::PRE_MASK64;
		end else if (CTL_IN.clk_sel == tcm_pkg::SEL_DIV256) begin
			tick = (st.pre & tcm_pkg::PRE_MASK256) == tcm_pkg::PRE_MASK256;
		end else if (CTL_IN.clk_sel == tcm_pkg::SEL_DIV1024) begin
			tick = st.pre == tcm_pkg::PRE_MASK1024;
		end else begin
			tick = 1'b0;
		end
	end

	// [RULE_20] match seen on the tick during equality, flag set at the next edge, [RULE_22] unless blocked
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_match
			assign match[g] = tick && !st.block && (st.counter_value == cmp[g]);
		end
	endgenerate

	// [RULE_14] top source chosen by waveform field only
	// [RULE_06] [RULE_09] mode fields never reach counting
	always_comb begin
		if (CTL_IN.waveform_generation_field == tcm_pkg::WGM_CTC_A) begin
			top_match = match[0];
		end else if (CTL_IN.waveform_generation_field == tcm_pkg::WGM_CTC_CAP) begin
			top_match = tick && !st.block && (st.counter_value == CAPTURE_IN);
		end else begin
			top_match = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_st = st;
		next_st.pre = (CTL_IN.clk_sel == tcm_pkg::SEL_STOP) ? tcm_pkg::PRE_RESET : st.pre + 10'h001;
		// [RULE_22] block lasts until the next timer tick
		if (tick) begin
			next_st.block = 1'b0;
		end
		// [RULE_11] count up and wrap; [RULE_24] top clear wins; [RULE_16] missed top wraps
		// [RULE_23] counter moves on enabled ticks only
		if (tick) begin
			if (top_match) begin
				next_st.counter_value = tcm_pkg::CNT_BOTTOM;
			end else begin
				next_st.counter_value = st.counter_value + 16'h0001;
			end
		end
		// [RULE_13] counter write at any time
		if (COUNT_WR_IN) begin
			next_st.counter_value = COUNT_DATA_IN;
			next_st.block = 1'b1;
		end
		// Service clears first so a same-cycle set wins
		next_st.flags = st.flags & ~FLAG_CLEAR_IN;
		// [RULE_12] overflow as the counter passes MAX
		// [RULE_19] same wrap rule in clear-on-compare
		if (tick && !top_match && st.counter_value == tcm_pkg::CNT_MAX) begin
			next_st.flags.overflow_flag = 1'b1;
		end
		// [RULE_15] top of mode 12 sets the capture flag
		if (top_match && CTL_IN.waveform_generation_field == tcm_pkg::WGM_CTC_CAP) begin
			next_st.flags.capture_flag = 1'b1;
		end
		for (int i = 0; i < 2; i++) begin
			// [RULE_20] compare flag on match
			if (match[i]) begin
				next_st.flags.channel_compare_flag[i] = 1'b1;
			end
			// [RULE_10] set, clear or toggle at a match; [RULE_07] zero holds
			// [RULE_17] toggle code flips state
			if (non_pwm && match[i]) begin
				next_st.output_compare_state[i] = apply_action(st.output_compare_state[i], com[i]);
			end
			// [RULE_21] force acts on state only
			// [RULE_08] mode change acts now via force
			if (non_pwm && FORCE_IN[i]) begin
				next_st.output_compare_state[i] = apply_action(st.output_compare_state[i], com[i]);
			end
			// [RULE_03] override of port data
			// [RULE_01] mode field picks pin source
			next_st.pin[i] = (com[i] != tcm_pkg::COM_OFF) ? next_st.output_compare_state[i] : PORT_DATA_IN[i];
			// [RULE_04] direction stays with the direction bit
			// [RULE_05] state settable while pin is input
			next_st.pin_oe_n[i] = ~PIN_DIR_IN[i];
		end
	end

	// [RULE_02] reset clears output states
	always_ff @(posedge CLOCK_IN) begin
		if (!NRST_IN) begin
			st <= '{pre: tcm_pkg::PRE_RESET, counter_value: tcm_pkg::CNT_BOTTOM, block: 1'b0,
				output_compare_state: tcm_pkg::OC_RESET, flags: '0, pin: 2'h0, pin_oe_n: 2'h3};
		end else begin
			st <= next_st;
		end
	end

	assign COUNT_OUT    = st.counter_value;
	assign FLAGS_OUT    = st.flags;
	assign STATE_OUT    = st.output_compare_state;
	assign PIN_OUT      = st.pin;
	assign PIN_OE_N_OUT = st.pin_oe_n;

	////////////////////////////////////////////////////////////////////////////
	a_reset_clears_state: assert property (@(posedge CLOCK_IN) // [RULE_02]
		!NRST_IN |=> STATE_OUT == tcm_pkg::OC_RESET)
		else $error("output state not cleared by reset");

	a_normal_wrap_ovf: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_12]
		tick && !COUNT_WR_IN && !top_match && COUNT_OUT == tcm_pkg::CNT_MAX
		|=> COUNT_OUT == tcm_pkg::CNT_BOTTOM && FLAGS_OUT.overflow_flag)
		else $error("wrap did not set overflow");

	a_ctc_clear_top: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_14]
		CTL_IN.waveform_generation_field == tcm_pkg::WGM_CTC_A && tick && !st.block && !COUNT_WR_IN
		&& COUNT_OUT == COMPARE_A_IN |=> COUNT_OUT == tcm_pkg::CNT_BOTTOM && FLAGS_OUT.channel_compare_flag[0])
		else $error("top match did not clear counter");

	a_capture_top_flag: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_15]
		CTL_IN.waveform_generation_field == tcm_pkg::WGM_CTC_CAP && tick && !st.block && !COUNT_WR_IN
		&& COUNT_OUT == CAPTURE_IN |=> FLAGS_OUT.capture_flag && COUNT_OUT == tcm_pkg::CNT_BOTTOM)
		else $error("capture top did not set capture flag");

	a_write_blocks_match: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_22]
		st.block && tick && FORCE_IN == 2'h0 |=> $stable(STATE_OUT))
		else $error("match not blocked after counter write");

	a_zero_mode_holds: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_07]
		CTL_IN.channel_a_output_mode_field == tcm_pkg::COM_OFF |=> STATE_OUT[0] == $past(STATE_OUT[0]))
		else $error("mode zero changed output state");

	a_force_toggles_only: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_21]
		FORCE_IN[0] && non_pwm && !tick && !COUNT_WR_IN && !FLAGS_OUT.channel_compare_flag[0]
		&& CTL_IN.channel_a_output_mode_field == tcm_pkg::COM_TOGGLE
		|=> STATE_OUT[0] != $past(STATE_OUT[0]) && !FLAGS_OUT.channel_compare_flag[0] && $stable(COUNT_OUT))
		else $error("force misbehaved");

	a_pin_override: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_03]
		CTL_IN.channel_a_output_mode_field != tcm_pkg::COM_OFF |=> PIN_OUT[0] == STATE_OUT[0])
		else $error("pin not driven by output state");

	a_dir_controls_oe: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_04]
		PIN_DIR_IN[0] |=> !PIN_OE_N_OUT[0])
		else $error("direction bit ignored");

	a_count_on_tick: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_23]
		!tick && !COUNT_WR_IN |=> $stable(COUNT_OUT))
		else $error("counter moved without tick");

	a_compare_b_flag: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_20]
		tick && !st.block && !COUNT_WR_IN && COUNT_OUT == COMPARE_B_IN
		|=> FLAGS_OUT.channel_compare_flag[1])
		else $error("compare B match did not set flag");

	a_ctc_overflow: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_19]
		CTL_IN.waveform_generation_field == tcm_pkg::WGM_CTC_A && tick && !COUNT_WR_IN && !top_match
		&& COUNT_OUT == tcm_pkg::CNT_MAX |=> FLAGS_OUT.overflow_flag)
		else $error("clear-on-compare wrap did not set overflow");

	a_top_clear_only: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_24]
		top_match && !COUNT_WR_IN && !FLAGS_OUT.overflow_flag
		|=> COUNT_OUT == tcm_pkg::CNT_BOTTOM && !FLAGS_OUT.overflow_flag)
		else $error("top clear wrong");

	a_toggle_on_match: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_17]
		match[0] && non_pwm && !FORCE_IN[0] && CTL_IN.channel_a_output_mode_field == tcm_pkg::COM_TOGGLE
		|=> STATE_OUT[0] != $past(STATE_OUT[0]))
		else $error("match did not toggle state");

	a_force_sets: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_08]
		FORCE_IN[0] && non_pwm && CTL_IN.channel_a_output_mode_field == tcm_pkg::COM_SET |=> STATE_OUT[0])
		else $error("force did not set state");

	a_force_clears: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_10]
		FORCE_IN[0] && non_pwm && CTL_IN.channel_a_output_mode_field == tcm_pkg::COM_CLEAR |=> !STATE_OUT[0])
		else $error("force did not clear state");

	a_pwm_no_action: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_10]
		!non_pwm |=> $stable(STATE_OUT))
		else $error("state changed outside non-PWM modes");

	a_port_passthrough: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_01]
		CTL_IN.channel_a_output_mode_field == tcm_pkg::COM_OFF |=> PIN_OUT[0] == $past(PORT_DATA_IN[0]))
		else $error("pin not driven by port data");

	a_write_loads: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_13]
		COUNT_WR_IN |=> COUNT_OUT == $past(COUNT_DATA_IN))
		else $error("counter write lost");

	a_normal_no_clear: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_11]
		CTL_IN.waveform_generation_field == tcm_pkg::WGM_NORMAL && tick && !COUNT_WR_IN
		|=> COUNT_OUT == $past(COUNT_OUT) + 16'h0001)
		else $error("normal mode did not count up");

	a_pin_oe_input: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [RULE_05]
		!PIN_DIR_IN[0] |=> PIN_OE_N_OUT[0])
		else $error("pin driven while input");

	c_ctc_top: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN) top_match ##[1:16] top_match);
	c_overflow: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN) $rose(FLAGS_OUT.overflow_flag));
	c_force: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN) FORCE_IN[0] && non_pwm);
	c_blocked: cover property (@(posedge CLOCK_IN) disable iff (!NRST_IN)
		st.block && tick && COUNT_OUT == COMPARE_A_IN);

endmodule

/* File: include/tcm_pkg.sv */
// Constants and carrier types of the 16-bit compare-output timer
package tcm_pkg;
	localparam logic [3:0]  WGM_NORMAL   = 4'h0;
	localparam logic [3:0]  WGM_CTC_A    = 4'h4;
	localparam logic [3:0]  WGM_CTC_CAP  = 4'hC;
	localparam logic [1:0]  COM_OFF      = 2'h0;
	localparam logic [1:0]  COM_TOGGLE   = 2'h1;
	localparam logic [1:0]  COM_CLEAR    = 2'h2;
	localparam logic [1:0]  COM_SET      = 2'h3;
	localparam logic [15:0] CNT_MAX      = 16'hFFFF;
	localparam logic [15:0] CNT_BOTTOM   = 16'h0000;
	localparam logic [1:0]  OC_RESET     = 2'h0;
	localparam logic [2:0]  SEL_STOP     = 3'h0;
	localparam logic [2:0]  SEL_DIV1     = 3'h1;
	localparam logic [2:0]  SEL_DIV8     = 3'h2;
	localparam logic [2:0]  SEL_DIV64    = 3'h3;
	localparam logic [2:0]  SEL_DIV256   = 3'h4;
	localparam logic [2:0]  SEL_DIV1024  = 3'h5;
	localparam logic [9:0]  PRE_MASK8    = 10'h007;
	localparam logic [9:0]  PRE_MASK64   = 10'h03F;
	localparam logic [9:0]  PRE_MASK256  = 10'h0FF;
	localparam logic [9:0]  PRE_MASK1024 = 10'h3FF;
	localparam logic [9:0]  PRE_RESET    = 10'h000;

	// Mode settings, all from same-clock control registers
	typedef struct packed {
		logic [2:0] clk_sel;
		logic [3:0] waveform_generation_field;
		logic [1:0] channel_b_output_mode_field;
		logic [1:0] channel_a_output_mode_field;
	} tcm_ctl_t;

	// Flags: capture, compare B, compare A, overflow
	typedef struct packed {
		logic       capture_flag;
		logic [1:0] channel_compare_flag;
		logic       overflow_flag;
	} tcm_flags_t;

	typedef struct packed {
		logic [9:0]  pre;
		logic [15:0] counter_value;
		logic        block;
		logic [1:0]  output_compare_state;
		tcm_flags_t  flags;
		logic [1:0]  pin;
		logic [1:0]  pin_oe_n;
	} tcm_state_t;
endpackage

/* File: test/tcm_pin_model.sv */
// Circuitry on the two compare pins
`timescale 1ns/1ns
module tcm_pin_model (
	// Pins from the timer
	input  wire logic [1:0] pin_in,
	input  wire logic [1:0] pin_oe_n_in,
	// Level seen outside
	output logic [1:0]      level_out
);
	// direction gates pin
	// Released pins rest on a pull-up, so a stale driven value never shows
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			level_out[i] = pin_oe_n_in[i] ? 1'b1 : pin_in[i];
		end
	end
endmodule

/* File: test/testbench.sv */
// Self-checking bench of the compare-output timer
`timescale 1ns/1ns
module testbench;
	logic                clock = 1'b0;
	logic                nrst  = 1'b0;
	tcm_pkg::tcm_ctl_t   ctl   = '0;
	logic [15:0]         cmp_a = 16'h0000;
	logic [15:0]         cmp_b = 16'h0000;
	logic [15:0]         cap   = 16'h0000;
	logic                wr    = 1'b0;
	logic [15:0]         wdata = 16'h0000;
	logic [1:0]          frc   = 2'h0;
	tcm_pkg::tcm_flags_t fclr  = '0;
	logic [1:0]          pdata = 2'h0;
	logic [1:0]          pdir  = 2'h0;
	logic [15:0]         count;
	tcm_pkg::tcm_flags_t flags;
	logic [1:0]          state;
	logic [1:0]          pin;
	logic [1:0]          oe_n;
	logic [1:0]          level;
	int                  num_errors = 0;
	int                  num_checks = 0;

	tcm_timer i_tcm_timer (.CLOCK_IN(clock), .NRST_IN(nrst), .CTL_IN(ctl), .COMPARE_A_IN(cmp_a),
		.COMPARE_B_IN(cmp_b), .CAPTURE_IN(cap), .COUNT_WR_IN(wr), .COUNT_DATA_IN(wdata), .FORCE_IN(frc),
		.FLAG_CLEAR_IN(fclr), .PORT_DATA_IN(pdata), .PIN_DIR_IN(pdir), .COUNT_OUT(count),
		.FLAGS_OUT(flags), .STATE_OUT(state), .PIN_OUT(pin), .PIN_OE_N_OUT(oe_n));
	tcm_pin_model i_tcm_pin_model (.pin_in(pin), .pin_oe_n_in(oe_n), .level_out(level));

	initial begin
		forever #4 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic reset_pulse(input int n);
		@(posedge clock);
		nrst <= 1'b0;
		repeat (n) @(posedge clock);
		nrst <= 1'b1;
		#1;
		check({count, 14'h0, state}, {16'h0000, 16'h0000}, "state after reset");
		check({24'h000000, flags, pin, oe_n}, 32'h00000003, "flags and pins after reset");
	endtask

	task automatic write_count(input logic [15:0] d);
		@(posedge clock);
		wr    <= 1'b1;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
		#1;
		check({16'h0000, count}, {16'h0000, d}, "written count");
	endtask

	task automatic clear_flags;
		@(posedge clock);
		fclr <= '1;
		@(posedge clock);
		fclr <= '0;
	endtask

	// Counts cycles up to the next change of channel A state
	task automatic wait_toggle(output int n);
		logic old;
		old = state[0];
		n = 0;
		while (state[0] === old) begin
			@(posedge clock);
			#1;
			n++;
			if (n > 20000) begin
				num_errors++;
				$display("unexpected at %0t: no toggle", $time);
				stop_test();
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic run_ctc(input logic [3:0] wgm, input logic [2:0] sel, input int div);
		int  n;
		bit  top_a;
		top_a = (wgm == tcm_pkg::WGM_CTC_A);
		@(posedge clock);
		ctl.clk_sel                     <= tcm_pkg::SEL_STOP;
		ctl.waveform_generation_field   <= wgm;
		ctl.channel_a_output_mode_field <= tcm_pkg::COM_TOGGLE;
		cmp_a                           <= top_a ? 16'h0002 : 16'h0001;
		cap                             <= 16'h0003;
		write_count(16'h0000);
		clear_flags();
		@(posedge clock);
		ctl.clk_sel <= sel;
		wait_toggle(n);
		wait_toggle(n);
		check(32'(n), 32'(div * (top_a ? 3 : 4)), "toggle period");
		check({16'h0000, count}, top_a ? 32'h00000000 : 32'h00000002, "count at toggle");
		check({30'h0, top_a ? flags.channel_compare_flag[0] : flags.capture_flag, flags.overflow_flag},
			32'h00000002, "top and overflow flags");
	endtask

	task automatic run_overflow_block;
		@(posedge clock);
		ctl.clk_sel                   <= tcm_pkg::SEL_STOP;
		ctl.waveform_generation_field <= tcm_pkg::WGM_NORMAL;
		cmp_b                         <= 16'h0010;
		// Load and clear while stopped so no early wrap sets the flag
		write_count(16'hFFFE);
		clear_flags();
		@(posedge clock);
		ctl.clk_sel <= tcm_pkg::SEL_DIV1;
		@(posedge clock);
		#1 check({count, 15'h0, flags.overflow_flag}, {16'hFFFF, 16'h0000}, "before wrap");
		@(posedge clock);
		#1 check({count, 15'h0, flags.overflow_flag}, {16'h0000, 16'h0001}, "wrap");
		write_count(16'h0010);
		repeat (2) @(posedge clock);
		#1 check({15'h0, flags.channel_compare_flag[1]}, 16'h0000, "blocked match");
		write_count(16'h000F);
		repeat (2) @(posedge clock);
		#1 check({count, 15'h0, flags.channel_compare_flag[1]}, {16'h0011, 16'h0001}, "late match");
	endtask

	task automatic run_force;
		logic [1:0]  com [5] = '{tcm_pkg::COM_CLEAR, tcm_pkg::COM_SET, tcm_pkg::COM_TOGGLE,
			tcm_pkg::COM_OFF, tcm_pkg::COM_TOGGLE};
		logic        exp [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
		logic [15:0] held;
		@(posedge clock);
		ctl.clk_sel <= tcm_pkg::SEL_STOP;
		pdata       <= 2'h3;
		pdir        <= 2'h0;
		ctl.channel_a_output_mode_field <= tcm_pkg::COM_SET;
		frc         <= 2'h1;
		@(posedge clock);
		frc <= 2'h0;
		#1 check({29'h0, state[0], oe_n[0], level[0]}, 32'h00000007, "state set while input");
		clear_flags();
		@(posedge clock);
		pdir <= 2'h1;
		held = count;
		for (int i = 0; i < 5; i++) begin
			@(posedge clock);
			ctl.channel_a_output_mode_field <= com[i];
			frc                             <= 2'h1;
			@(posedge clock);
			frc <= 2'h0;
			#1 check(32'(state[0]), 32'(exp[i]), "forced state");
			check({30'h0, pin[0], level[0]}, (com[i] == tcm_pkg::COM_OFF) ? 32'h00000003 : {30'h0, {2{exp[i]}}},
				"pin source");
		end
		check({count, 12'h0, flags}, {held, 16'h0000}, "force leaves count and flags");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int divs [5] = '{1, 8, 64, 256, 1024};
		reset_pulse(5);
		for (int i = 0; i < 5; i++) begin
			run_ctc(tcm_pkg::WGM_CTC_A, 3'(i + 1), divs[i]);
		end
		run_ctc(tcm_pkg::WGM_CTC_CAP, tcm_pkg::SEL_DIV8, 8);
		run_overflow_block();
		run_force();
		reset_pulse(1);
		stop_test();
	end
endmodule
